/* rtl/fpl_pkg.sv */
// Constants for the front panel switch and indicator logic
package fpl_pkg;
    // Register indices on the plain register port
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_LEVEL = 4'h1;
    localparam logic [3:0] ADDR_STATUS = 4'h2;
    localparam logic [3:0] ADDR_MASK = 4'h3;
    localparam logic [3:0] ADDR_STATE = 4'h4;
    // Control register fields
    localparam int CTRL_RESET_EN = 0;
    localparam int CTRL_ABORT_EN = 1;
    localparam int CTRL_FALLBACK_EN = 2;
    localparam logic [2:0] CTRL_RESET = 3'h1;
    // Status and mask fields
    localparam int EV_RESET = 0;
    localparam int EV_ABORT = 1;
    localparam int EV_WIDTH = 2;
    localparam logic [2:0] LEVEL_RESET = 3'h0;
    // Debounce and reset pulse timing
    localparam int CLK_PERIOD_PS = 5000;
    localparam int DEBOUNCE_MS = 10;
    localparam int DEBOUNCE_CYC = DEBOUNCE_MS * (1000000000 / CLK_PERIOD_PS);
    localparam int RESET_PULSE_US = 1;
    localparam int RESET_PULSE_CYC = RESET_PULSE_US * (1000000 / CLK_PERIOD_PS);
endpackage

/* rtl/fpl_evt_if.sv */
// Press event carrier between debouncer and main logic
`timescale 1ns/10ps
interface fpl_evt_if;
    logic press;
    logic level;
    modport src (
        output press,
        output level
    );
    modport dst (
        input press,
        input level
    );
endinterface

/* rtl/fpl_debounce.sv */
// Debouncer for one active-low pushbutton
`timescale 1ns/10ps
module fpl_debounce #(
    parameter int DEBOUNCE_CYC = fpl_pkg::DEBOUNCE_CYC
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_button_n,
    fpl_evt_if.src evt
);
    typedef struct packed {
        logic sync1;
        logic sync2;
        logic stable;
        logic [31:0] count;
        logic press;
    } db_state_t;

    db_state_t st;
    db_state_t next_st;

    always_comb begin
        next_st = st;
        next_st.sync1 = ~i_button_n;
        next_st.sync2 = st.sync1;
        next_st.press = 1'b0;
        if (st.sync2 == st.stable) begin
            next_st.count = 32'h0;
        end else if (st.count >= 32'(DEBOUNCE_CYC - 1)) begin
            next_st.count = 32'h0;
            next_st.stable = st.sync2;
            // High-to-low pin edge counts as the press
            next_st.press = st.sync2;
        end else begin
            next_st.count = st.count + 32'h1;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign evt.press = st.press;
    assign evt.level = st.stable;
endmodule // fpl_debounce

/* rtl/fpl_front_panel.sv */
// Front panel switch and indicator logic
//
// How it works
// - A taken reset press drives the onboard reset for a fixed pulse.
// - As system controller, a reset press also drives the backplane reset.
// - Software can disable the reset button so presses reset nothing.
// - An enabled abort press raises an interrupt at a programmed level.
// - Fail lamp lights on board fail low or processor halted.
// - Run lamp lights while transfer_in_progress_n is low.
// - System controller lamp follows the system controller role.
// - Starred levels are active low, starred edges act on the fall.
// - Fallback bridge functions stay off whenever the bridge is fitted.
`timescale 1ns/10ps
module fpl_front_panel #(
    parameter int DEBOUNCE_CYC = fpl_pkg::DEBOUNCE_CYC,
    parameter int RESET_PULSE_CYC = fpl_pkg::RESET_PULSE_CYC
) (
    input wire logic I_CLK_SYS,
    input wire logic I_RESETN,
    input wire logic i_reset_button_n,
    input wire logic i_abort_button_n,
    input wire logic i_board_fail_n,
    input wire logic i_cpu_halted,
    input wire logic i_transfer_in_progress_n,
    input wire logic i_sys_controller,
    input wire logic i_bridge_fitted,
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    output logic o_onboard_reset_n,
    output logic o_sysreset_n,
    output logic o_sysreset_oe_n,
    output logic o_abort_irq,
    output logic [2:0] o_abort_irq_level,
    output logic o_irq,
    output logic o_fail_led,
    output logic o_run_led,
    output logic o_system_controller_led,
    output logic o_fallback_en
);
    typedef struct packed {
        logic [2:0] ctrl;
        logic [2:0] level;
        logic [fpl_pkg::EV_WIDTH-1:0] status;
        logic [fpl_pkg::EV_WIDTH-1:0] mask;
        logic [7:0] rdata;
        logic [31:0] rst_count;
        logic rst_active;
        logic sys_rst;
        logic abort_pend;
        logic fail_led;
        logic run_led;
        logic system_controller_led_led;
    } fp_state_t;

    fp_state_t st;
    fp_state_t next_st;
    fpl_evt_if reset_evt ();
    fpl_evt_if abort_evt ();

    // ----------------------------------------------------------------
    // Pushbutton conditioning
    // ----------------------------------------------------------------
    fpl_debounce #(
        .DEBOUNCE_CYC(DEBOUNCE_CYC)
    ) u_reset_db (
        .i_clk(I_CLK_SYS),
        .i_resetn(I_RESETN),
        .i_button_n(i_reset_button_n),
        .evt(reset_evt.src)
    );

    fpl_debounce #(
        .DEBOUNCE_CYC(DEBOUNCE_CYC)
    ) u_abort_db (
        .i_clk(I_CLK_SYS),
        .i_resetn(I_RESETN),
        .i_button_n(i_abort_button_n),
        .evt(abort_evt.src)
    );

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    logic reset_take;
    logic abort_take;
    logic [fpl_pkg::EV_WIDTH-1:0] ev_set;
    logic [fpl_pkg::EV_WIDTH-1:0] ev_clr;

    assign reset_take = reset_evt.press
                      & st.ctrl[fpl_pkg::CTRL_RESET_EN];
    assign abort_take = abort_evt.press
                      & st.ctrl[fpl_pkg::CTRL_ABORT_EN];

    always_comb begin
        ev_set = '0;
        ev_set[fpl_pkg::EV_RESET] = reset_take;
        ev_set[fpl_pkg::EV_ABORT] = abort_take;
        ev_clr = '0;
        if (i_wr && i_addr == fpl_pkg::ADDR_STATUS) begin
            ev_clr = i_wdata[fpl_pkg::EV_WIDTH-1:0];
        end
    end

    always_comb begin
        next_st = st;
        // Register writes
        if (i_wr) begin
            case (i_addr)
                fpl_pkg::ADDR_CTRL: next_st.ctrl = i_wdata[2:0];
                fpl_pkg::ADDR_LEVEL: next_st.level = i_wdata[2:0];
                fpl_pkg::ADDR_MASK: begin
                    next_st.mask = i_wdata[fpl_pkg::EV_WIDTH-1:0];
                end
                default: begin
                end
            endcase
        end
        // Set wins over write-one-to-clear
        next_st.status = (st.status & ~ev_clr) | ev_set;
        // Reads answer one cycle later
        next_st.rdata = 8'h00;
        if (i_rd) begin
            case (i_addr)
                fpl_pkg::ADDR_CTRL: next_st.rdata = {5'h00, st.ctrl};
                fpl_pkg::ADDR_LEVEL: next_st.rdata = {5'h00, st.level};
                fpl_pkg::ADDR_STATUS: begin
                    next_st.rdata = {6'h00, st.status};
                end
                fpl_pkg::ADDR_MASK: next_st.rdata = {6'h00, st.mask};
                fpl_pkg::ADDR_STATE: begin
                    next_st.rdata = {1'b0, st.rst_active,
                                     reset_evt.level,
                                     abort_evt.level,
                                     st.fail_led, st.run_led,
                                     st.system_controller_led_led, st.abort_pend};
                end
                default: next_st.rdata = 8'h00;
            endcase
        end
        // Reset pulse generator
        if (reset_take) begin
            next_st.rst_active = 1'b1;
            next_st.sys_rst = i_sys_controller;
            next_st.rst_count = 32'(RESET_PULSE_CYC - 1);
        end else if (st.rst_active) begin
            if (st.rst_count == 32'h0) begin
                next_st.rst_active = 1'b0;
                next_st.sys_rst = 1'b0;
            end else begin
                next_st.rst_count = st.rst_count - 32'h1;
            end
        end
        // Abort interrupt held until software clears the status bit
        next_st.abort_pend = next_st.status[fpl_pkg::EV_ABORT];
        // Indicators, i_board_fail_n and i_transfer_in_progress_n active low
        next_st.fail_led = ~i_board_fail_n | i_cpu_halted;
        next_st.run_led = ~i_transfer_in_progress_n;
        next_st.system_controller_led_led = i_sys_controller;
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
        if (!I_RESETN) begin
            st <= '0;
            st.ctrl <= fpl_pkg::CTRL_RESET;
            st.level <= fpl_pkg::LEVEL_RESET;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign o_rdata = st.rdata;
    assign o_onboard_reset_n = ~st.rst_active;
    assign o_sysreset_n = ~st.sys_rst;
    assign o_sysreset_oe_n = ~st.sys_rst;
    assign o_abort_irq = st.abort_pend;
    assign o_abort_irq_level = st.level;
    assign o_irq = |(st.status & st.mask);
    assign o_fail_led = st.fail_led;
    assign o_run_led = st.run_led;
    assign o_system_controller_led = st.system_controller_led_led;
    assign o_fallback_en = st.ctrl[fpl_pkg::CTRL_FALLBACK_EN]
                         & ~i_bridge_fitted;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    AST_RESET_PULSE: assert property (
        @(posedge I_CLK_SYS) disable iff (!I_RESETN)
        reset_take |=> !o_onboard_reset_n)
        else $error("Reset press gave no onboard reset");

    AST_SYSRESET: assert property (
        @(posedge I_CLK_SYS) disable iff (!I_RESETN)
        reset_take && i_sys_controller |=> !o_sysreset_n && !o_sysreset_oe_n)
        else $error("System controller press gave no backplane reset");

    AST_RESET_DISABLED: assert property (
        @(posedge I_CLK_SYS) disable iff (!I_RESETN)
        reset_evt.press && !st.ctrl[fpl_pkg::CTRL_RESET_EN]
            && o_onboard_reset_n |=> o_onboard_reset_n)
        else $error("Disabled reset button reset the board");

    AST_ABORT_IRQ: assert property (
        @(posedge I_CLK_SYS) disable iff (!I_RESETN)
        abort_evt.press |=>
            (o_abort_irq == ($past(st.ctrl[fpl_pkg::CTRL_ABORT_EN])
             || ($past(st.abort_pend)
                 && !$past(ev_clr[fpl_pkg::EV_ABORT])))))
        else $error("Abort interrupt does not follow its enable");

    AST_FAIL_LED: assert property (
        @(posedge I_CLK_SYS) disable iff (!I_RESETN)
        (!i_board_fail_n || i_cpu_halted) |=> o_fail_led)
        else $error("Fail lamp dark while failure present");

    AST_RUN_LED: assert property (
        @(posedge I_CLK_SYS) disable iff (!I_RESETN)
        ##1 o_run_led == !$past(i_transfer_in_progress_n))
        else $error("Run lamp does not follow transfer activity");

    AST_SYSTEM_CONTROLLER_LED_LED: assert property (
        @(posedge I_CLK_SYS) disable iff (!I_RESETN)
        $rose(i_sys_controller) |=> o_system_controller_led)
        else $error("System controller lamp missed the role");

    AST_FALLBACK: assert property (
        @(posedge I_CLK_SYS) disable iff (!I_RESETN)
        i_bridge_fitted |-> !o_fallback_en)
        else $error("Fallback on while bridge fitted");

    AST_ONE_PRESS: assert property (
        @(posedge I_CLK_SYS) disable iff (!I_RESETN)
        reset_evt.press |=> !reset_evt.press [*2])
        else $error("One press gave several events");

    AST_ONE_ABORT: assert property (
        @(posedge I_CLK_SYS) disable iff (!I_RESETN)
        abort_evt.press |=> !abort_evt.press [*2])
        else $error("One abort press gave several events");

    AST_PRESS_EDGE: assert property (
        @(posedge I_CLK_SYS) disable iff (!I_RESETN)
        reset_evt.press |-> reset_evt.level && !$past(reset_evt.level))
        else $error("Reset event without a fresh press");

    AST_ABORT_EDGE: assert property (
        @(posedge I_CLK_SYS) disable iff (!I_RESETN)
        abort_evt.press |-> abort_evt.level && !$past(abort_evt.level))
        else $error("Abort event without a fresh press");

    AST_RESET_HOLD: assert property (
        @(posedge I_CLK_SYS) disable iff (!I_RESETN)
        !o_onboard_reset_n && st.rst_count != 32'h0 |=> !o_onboard_reset_n)
        else $error("Reset pulse ended early");

    AST_RESET_END: assert property (
        @(posedge I_CLK_SYS) disable iff (!I_RESETN)
        st.rst_active && st.rst_count == 32'h0 && !reset_take
            |=> o_onboard_reset_n && o_sysreset_n)
        else $error("Reset pulse did not end on time");

    AST_RESET_SOURCE: assert property (
        @(posedge I_CLK_SYS) disable iff (!I_RESETN)
        $fell(o_onboard_reset_n) |-> $past(reset_take))
        else $error("Onboard reset without a taken press");

    AST_STATUS_ON_TAKE: assert property (
        @(posedge I_CLK_SYS) disable iff (!I_RESETN)
        reset_take |=> st.status[fpl_pkg::EV_RESET])
        else $error("Taken reset press left no status bit");

    AST_SYS_SOURCE: assert property (
        @(posedge I_CLK_SYS) disable iff (!I_RESETN)
        $fell(o_sysreset_n) |-> $past(reset_take && i_sys_controller))
        else $error("Backplane reset without controller press");

    AST_SYS_WITH_BOARD: assert property (
        @(posedge I_CLK_SYS) disable iff (!I_RESETN)
        !o_sysreset_n |-> !o_onboard_reset_n)
        else $error("Backplane reset without onboard reset");

    AST_OE_DRIVE: assert property (
        @(posedge I_CLK_SYS) disable iff (!I_RESETN)
        !o_sysreset_oe_n |-> !o_sysreset_n)
        else $error("Backplane line enabled while not driven low");

    AST_STATUS_DISABLED: assert property (
        @(posedge I_CLK_SYS) disable iff (!I_RESETN)
        reset_evt.press && !st.ctrl[fpl_pkg::CTRL_RESET_EN]
            && !st.status[fpl_pkg::EV_RESET]
            |=> !st.status[fpl_pkg::EV_RESET])
        else $error("Disabled reset button set its status bit");

    AST_SYS_DISABLED: assert property (
        @(posedge I_CLK_SYS) disable iff (!I_RESETN)
        reset_evt.press && !st.ctrl[fpl_pkg::CTRL_RESET_EN]
            && o_sysreset_n |=> o_sysreset_n)
        else $error("Disabled reset button drove the backplane reset");

    AST_ABORT_OFF: assert property (
        @(posedge I_CLK_SYS) disable iff (!I_RESETN)
        abort_evt.press && !st.ctrl[fpl_pkg::CTRL_ABORT_EN]
            && !o_abort_irq |=> !o_abort_irq)
        else $error("Disabled abort button raised an interrupt");

    AST_ABORT_STATUS: assert property (
        @(posedge I_CLK_SYS) disable iff (!I_RESETN)
        abort_take |=> o_abort_irq)
        else $error("Enabled abort press raised no interrupt");

    AST_ABORT_HELD: assert property (
        @(posedge I_CLK_SYS) disable iff (!I_RESETN)
        o_abort_irq && !ev_clr[fpl_pkg::EV_ABORT] |=> o_abort_irq)
        else $error("Abort interrupt dropped before its clear");

    AST_ABORT_CLEAR: assert property (
        @(posedge I_CLK_SYS) disable iff (!I_RESETN)
        o_abort_irq && ev_clr[fpl_pkg::EV_ABORT] && !abort_take
            |=> !o_abort_irq)
        else $error("Abort interrupt survived its clear");

    AST_LEVEL_WRITE: assert property (
        @(posedge I_CLK_SYS) disable iff (!I_RESETN)
        i_wr && i_addr == fpl_pkg::ADDR_LEVEL
            |=> o_abort_irq_level == $past(i_wdata[2:0]))
        else $error("Interrupt level not taken from software");

    AST_FAIL_OFF: assert property (
        @(posedge I_CLK_SYS) disable iff (!I_RESETN)
        i_board_fail_n && !i_cpu_halted |=> !o_fail_led)
        else $error("Fail lamp lit with no failure");

    AST_SYSTEM_CONTROLLER_LED_FOLLOW: assert property (
        @(posedge I_CLK_SYS) disable iff (!I_RESETN)
        ##1 o_system_controller_led == $past(i_sys_controller))
        else $error("System controller lamp does not follow the role");

    AST_FALLBACK_SW: assert property (
        @(posedge I_CLK_SYS) disable iff (!I_RESETN)
        !st.ctrl[fpl_pkg::CTRL_FALLBACK_EN] |-> !o_fallback_en)
        else $error("Fallback on without software enable");
endmodule // fpl_front_panel

/* test/fpl_panel_model.sv */
// Front panel pushbutton model with contact bounce
`timescale 1ns/10ps
module fpl_panel_model #(
    parameter int BOUNCE = 3
) (
    input wire logic i_clk,
    input wire logic i_push,
    output logic o_button_n
);
    int cnt = 0;
    logic last = 1'b0;
    initial o_button_n = 1'b1;
    // ----
    // Bounce on each change, then settle low while pushed
    // ----
    always @(posedge i_clk) begin
        if (i_push !== last) begin
            last <= i_push;
            cnt <= BOUNCE;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
            o_button_n <= ~o_button_n;
        end else begin
            o_button_n <= ~last;
        end
    end
endmodule // fpl_panel_model

/* test/tb.sv */
// Self-checking bench for the front panel logic
`timescale 1ns/10ps
module tb;
    logic clk = 0, rstn = 0, push_rst = 0, push_abt = 0, prev_obr = 1;
    logic bf_n = 1, halt = 0, tip_n = 1, sc = 0, bridge = 0, wr = 0, rd = 0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00, rdata;
    logic rst_btn_n, abt_btn_n, obr_n, sys_n, sys_oe_n, abt_irq, irq;
    logic fail_led, run_led, system_controller_led_led, fb_en;
    logic [2:0] lvl;
    int failures = 0, checks_done = 0, cyc = 0;
    int falls = 0, low_cyc = 0, sys_cyc = 0, oe_bad = 0;
    initial forever #2.5 clk = ~clk;
    fpl_panel_model u_rst (.i_clk(clk), .i_push(push_rst),
        .o_button_n(rst_btn_n));
    fpl_panel_model u_abt (.i_clk(clk), .i_push(push_abt),
        .o_button_n(abt_btn_n));
    fpl_front_panel #(.DEBOUNCE_CYC(4), .RESET_PULSE_CYC(3)) dut (
        .I_CLK_SYS(clk), .I_RESETN(rstn), .i_reset_button_n(rst_btn_n),
        .i_abort_button_n(abt_btn_n), .i_board_fail_n(bf_n),
        .i_cpu_halted(halt), .i_transfer_in_progress_n(tip_n),
        .i_sys_controller(sc), .i_bridge_fitted(bridge), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .o_onboard_reset_n(obr_n), .o_sysreset_n(sys_n),
        .o_sysreset_oe_n(sys_oe_n), .o_abort_irq(abt_irq),
        .o_abort_irq_level(lvl), .o_irq(irq), .o_fail_led(fail_led),
        .o_run_led(run_led), .o_system_controller_led(system_controller_led_led),
        .o_fallback_en(fb_en));
    // ----
    // Pulse monitors and timeout
    // ----
    always @(posedge clk) begin
        cyc <= cyc + 1;
        prev_obr <= obr_n;
        if (prev_obr === 1'b1 && obr_n === 1'b0) falls <= falls + 1;
        if (obr_n === 1'b0) low_cyc <= low_cyc + 1;
        if (sys_n === 1'b0) sys_cyc <= sys_cyc + 1;
        if (sys_oe_n !== sys_n) oe_bad <= oe_bad + 1;
        if (cyc == 5000) begin
            failures++;
            end_of_test();
        end
    end
    // ----
    // Tasks
    // ----
    task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task rd_chk(input logic [3:0] a, input logic [7:0] exp, input string n);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(n, exp, rdata);
    endtask
    task press(input logic abort);
        falls = 0;
        low_cyc = 0;
        sys_cyc = 0;
        @(posedge clk);
        if (abort) push_abt <= 1'b1;
        else push_rst <= 1'b1;
        repeat (30) @(posedge clk);
        push_abt <= 1'b0;
        push_rst <= 1'b0;
        repeat (30) @(posedge clk);
        #1;
    endtask
    task end_of_test;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // ----
    // Tests
    // ----
    initial begin
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        rd_chk(fpl_pkg::ADDR_CTRL, {5'h00, fpl_pkg::CTRL_RESET}, "ctrl");
        rd_chk(fpl_pkg::ADDR_LEVEL, {5'h00, fpl_pkg::LEVEL_RESET}, "level");
        rd_chk(fpl_pkg::ADDR_STATUS, 8'h00, "status");
        rd_chk(fpl_pkg::ADDR_MASK, 8'h00, "mask");
        wr_reg(4'hF, 8'hFF);
        rd_chk(4'hF, 8'h00, "unmapped");
        $display("test registers done");
        for (int i = 0; i < 16; i++) begin
            @(posedge clk);
            {bf_n, halt, tip_n, sc} <= i[3:0];
            repeat (3) @(posedge clk);
            #1 chk("fail", {7'h00, ~bf_n | halt}, {7'h00, fail_led});
            chk("run", {7'h00, ~tip_n}, {7'h00, run_led});
            chk("system_controller_led", {7'h00, sc}, {7'h00, system_controller_led_led});
        end
        rd_chk(fpl_pkg::ADDR_STATE, 8'h0A, "state");
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            bridge <= i[1];
            wr_reg(fpl_pkg::ADDR_CTRL, {5'h00, i[0], 2'b01});
            chk("fallback", {7'h00, i[0] & ~i[1]}, {7'h00, fb_en});
        end
        $display("test indicators done");
        @(posedge clk);
        sc <= 1'b1;
        wr_reg(fpl_pkg::ADDR_MASK, 8'h03);
        press(1'b0);
        chk("reset falls", 8'h01, 8'(falls));
        chk("reset width", 8'h03, 8'(low_cyc));
        chk("sysreset width", 8'h03, 8'(sys_cyc));
        chk("irq", 8'h01, {7'h00, irq});
        rd_chk(fpl_pkg::ADDR_STATUS, 8'h01, "status");
        wr_reg(fpl_pkg::ADDR_STATUS, 8'h01);
        chk("irq clear", 8'h00, {7'h00, irq});
        @(posedge clk);
        sc <= 1'b0;
        press(1'b0);
        chk("reset falls", 8'h01, 8'(falls));
        chk("sysreset idle", 8'h00, 8'(sys_cyc));
        wr_reg(fpl_pkg::ADDR_STATUS, 8'h03);
        wr_reg(fpl_pkg::ADDR_CTRL, 8'h00);
        press(1'b0);
        chk("disabled falls", 8'h00, 8'(falls));
        press(1'b1);
        chk("abort off", 8'h00, {7'h00, abt_irq});
        rd_chk(fpl_pkg::ADDR_STATUS, 8'h00, "status");
        $display("test reset button done");
        for (int i = 2; i < 8; i += 5) begin
            wr_reg(fpl_pkg::ADDR_LEVEL, 8'(i));
            wr_reg(fpl_pkg::ADDR_CTRL, 8'h02);
            chk("level", 8'(i), {5'h00, lvl});
            press(1'b1);
            chk("abort irq", 8'h01, {7'h00, abt_irq});
            chk("irq", 8'h01, {7'h00, irq});
            chk("abort falls", 8'h00, 8'(falls));
            rd_chk(fpl_pkg::ADDR_STATE, 8'h09, "state");
            wr_reg(fpl_pkg::ADDR_STATUS, 8'h02);
            chk("abort clear", 8'h00, {7'h00, abt_irq});
        end
        chk("oe tracks", 8'h00, 8'(oe_bad));
        $display("test abort done");
        end_of_test();
    end
endmodule // tb
